//--- hw/cimsb_core.sv
// Interrupt mask, result flags, stop mode and break handling for the processor core.
//
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
//
// Summary of operation
// - A set mask blocks all maskable requests; a clear mask lets them in.
// - Interrupt entry stacks registers, then sets the mask, then fetches the vector.
// - Entry stacks PC, low index, accumulator and flags, never the high index.
// - With several requests pending, the highest priority one is taken first.
// - Return from exception pulls the stacked registers and restores the mask.
// - Reset sets the mask; afterwards the clear-mask instruction, stop and a pulled flags byte can clear it.
// - Negative flag follows bit 7 of each operation result.
// - Zero flag is set when the eight-bit result is all zeros.
// - Stop clears the mask and halts the processor clock.
// - Interrupt wake keeps the mask clear; reset wake sets it.
// - Leaving stop on a request, the clock restarts after the oscillator settling wait; a reset restarts it at once.
// - An enabled break finishes the current instruction, then runs a software trap.
// - Break vector differs between normal operation and monitor mode.
// - Return from exception ends the break only once the break request dropped.
// - Requests are taken only on boundaries, wake stop on any cycle, and need their own enable.
module cimsb_core
    import cimsb_pkg::*;
#(
    parameter int NSRC        = 8,
    parameter int STAB_CYCLES = OSC_STAB_CYC
) (
    input  wire logic             i_ref_clk,     // Bus clock, 25 MHz.
    input  wire logic             i_resetn,      // Synchronous reset, active low.
    input  wire logic             i_ce,          // Clock enable, freezes all state.
    input  wire logic             i_boundary,    // Instruction boundary pulse.
    input  wire logic             i_cli_exec,    // Clear-mask instruction executed.
    input  wire logic             i_sei_exec,    // Set-mask instruction executed.
    input  wire logic             i_stop_exec,   // Stop instruction executed.
    input  wire logic             i_rti_exec,    // Return from exception executed.
    input  wire logic             i_alu_valid,   // Operation result present.
    input  wire logic [7:0]       i_alu_result,  // Operation result byte.
    input  wire logic [2:0]       i_ccr_vhc,     // Core owned V, H and C flags.
    input  wire logic [15:0]      i_pc,          // Return address to stack.
    input  wire logic [7:0]       i_acc,         // Accumulator to stack.
    input  wire logic [7:0]       i_idx_lo,      // Low index byte to stack.
    input  wire logic [7:0]       i_stack_rdata, // Stack byte during a pull.
    input  wire logic             i_ext_irq_pin, // External interrupt pin, source 0.
    input  wire logic [NSRC-1:1]  i_irq_req,     // On-chip peripheral requests.
    input  wire logic             i_break_en,    // Break module enabled.
    input  wire logic             i_break_req,   // Break request from break module.
    input  wire logic             i_monitor,     // Monitor mode select.
    input  wire logic [3:0]       i_addr,        // Register address.
    input  wire logic [31:0]      i_wdata,       // Register write data.
    input  wire logic             i_wr,          // Register write strobe.
    input  wire logic             i_rd,          // Register read strobe.
    output logic      [31:0]      o_rdata,       // Read data, cycle after strobe.
    output logic                  o_irq,         // Unmasked event interrupt.
    output logic                  o_busy,        // Core must hold its sequencer.
    output logic                  o_cpu_clk_en,  // Processor clock enable.
    output logic                  o_stack_wr,    // Stack push strobe.
    output logic                  o_stack_rd,    // Stack pull strobe.
    output logic      [2:0]       o_stack_idx,   // Byte number within push or pull.
    output logic      [7:0]       o_stack_data,  // Byte being pushed.
    output logic                  o_vec_fetch,   // Vector fetch pulse.
    output logic      [15:0]      o_vec_addr,    // Vector address to load.
    output logic                  o_mask_flag,   // Interrupt mask flag.
    output logic                  o_neg_flag,    // Negative flag.
    output logic                  o_zero_flag    // Zero flag.
);
    localparam int IW    = $clog2(NSRC);
    localparam int CNT_W = $clog2(STAB_CYCLES + 1);
    localparam logic [CNT_W-1:0] STAB_LAST = CNT_W'(STAB_CYCLES - 1);

    cimsb_state_type   state_q, state_d;
    logic [CNT_W-1:0]  cnt_q, cnt_d;
    logic              i_flag_q, i_flag_d;
    logic              n_flag_q, n_flag_d;
    logic              z_flag_q, z_flag_d;
    logic              brk_act_q, brk_act_d;
    logic [7:0]        sdata_q, sdata_d;
    logic [15:0]       vaddr_q, vaddr_d;
    logic [EV_W-1:0]   ev_q, ev_d;
    logic [EV_W-1:0]   evmask_q, evmask_d;
    logic [NSRC-1:0]   en_q, en_d;
    logic [31:0]       rdata_q, rdata_d;
    logic [EV_W-1:0]   ev_set;
    logic              ext_sync;
    logic [NSRC-1:0]   pend;
    logic              irq_valid;
    logic [IW-1:0]     irq_idx;
    logic              brk_take;
    logic              irq_take;
    logic [7:0]        ccr_byte;

    cimsb_sync #(.W(1)) u_sync (
        .i_ref_clk (i_ref_clk),
        .i_resetn  (i_resetn),
        .i_ce      (i_ce),
        .i_async   (i_ext_irq_pin),
        .o_sync    (ext_sync)
    );

    assign pend = {i_irq_req, ext_sync} & en_q;

    cimsb_prio #(.N(NSRC), .IW(IW)) u_prio (
        .i_req   (pend),
        .o_valid (irq_valid),
        .o_index (irq_idx)
    );

    assign brk_take = i_break_en && i_break_req && !brk_act_q;
    assign irq_take = irq_valid && !i_flag_q;

    always_comb
    begin
        ccr_byte        = 8'h60;
        ccr_byte[CCR_V] = i_ccr_vhc[2];
        ccr_byte[CCR_H] = i_ccr_vhc[1];
        ccr_byte[CCR_C] = i_ccr_vhc[0];
        ccr_byte[CCR_I] = i_flag_q;
        ccr_byte[CCR_N] = n_flag_q;
        ccr_byte[CCR_Z] = z_flag_q;
    end

    function automatic logic [7:0] push_byte(input logic [2:0] idx, input logic [15:0] pc,
                                             input logic [7:0] x, input logic [7:0] a,
                                             input logic [7:0] condition_code_register);
        logic [7:0] b;
        case (idx)
            3'h0:    b = pc[7:0];
            3'h1:    b = pc[15:8];
            3'h2:    b = x;
            3'h3:    b = a;
            default: b = condition_code_register;
        endcase
        return b;
    endfunction

    // Sequencer and flags.
    always_comb
    begin
        state_d   = state_q;
        cnt_d     = cnt_q;
        i_flag_d  = i_flag_q;
        n_flag_d  = n_flag_q;
        z_flag_d  = z_flag_q;
        brk_act_d = brk_act_q;
        sdata_d   = sdata_q;
        vaddr_d   = vaddr_q;
        ev_set    = '0;
        case (state_q)
            ST_RUN:
            begin
                if (i_alu_valid)
                begin
                    n_flag_d = i_alu_result[7];
                    z_flag_d = (i_alu_result == 8'h00);
                end
                if (i_cli_exec)
                begin
                    i_flag_d = 1'b0;
                end
                if (i_sei_exec)
                begin
                    i_flag_d = 1'b1;
                end
                if (i_rti_exec)
                begin
                    state_d = ST_PULL;
                    cnt_d   = '0;
                end
                else if (i_stop_exec)
                begin
                    i_flag_d = 1'b0;
                    state_d  = ST_STOP;
                end
                else if (i_boundary && brk_take)
                begin
                    brk_act_d = 1'b1;
                    vaddr_d   = i_monitor ? VEC_BRK_MON : VEC_BRK_NORMAL;
                    sdata_d   = push_byte(3'h0, i_pc, i_idx_lo, i_acc, ccr_byte);
                    cnt_d     = '0;
                    state_d   = ST_PUSH;
                    ev_set[EV_BRK] = 1'b1;
                end
                else if (i_boundary && irq_take)
                begin
                    vaddr_d   = VEC_IRQ_TOP - {15'(irq_idx), 1'b0};
                    sdata_d   = push_byte(3'h0, i_pc, i_idx_lo, i_acc, ccr_byte);
                    cnt_d     = '0;
                    state_d   = ST_PUSH;
                    ev_set[EV_INT] = 1'b1;
                end
            end
            ST_PUSH:
            begin
                if (cnt_q[2:0] == STACK_LAST)
                begin
                    i_flag_d = 1'b1;
                    state_d  = ST_VEC;
                end
                else
                begin
                    cnt_d   = cnt_q + CNT_W'(1);
                    sdata_d = push_byte(cnt_q[2:0] + 3'h1, i_pc, i_idx_lo, i_acc, ccr_byte);
                end
            end
            ST_VEC:
            begin
                state_d = ST_RUN;
            end
            ST_PULL:
            begin
                if (cnt_q == '0)
                begin
                    i_flag_d = i_stack_rdata[CCR_I];
                    n_flag_d = i_stack_rdata[CCR_N];
                    z_flag_d = i_stack_rdata[CCR_Z];
                end
                if (cnt_q[2:0] == STACK_LAST)
                begin
                    if (brk_act_q && !i_break_req)
                    begin
                        brk_act_d = 1'b0;
                    end
                    state_d = ST_RUN;
                end
                else
                begin
                    cnt_d = cnt_q + CNT_W'(1);
                end
            end
            ST_STOP:
            begin
                if (|pend)
                begin
                    cnt_d   = '0;
                    state_d = ST_STAB;
                    ev_set[EV_WAKE] = 1'b1;
                end
            end
            ST_STAB:
            begin
                if (cnt_q == STAB_LAST)
                begin
                    state_d = ST_RUN;
                end
                else
                begin
                    cnt_d = cnt_q + CNT_W'(1);
                end
            end
            default:
            begin
                state_d = ST_RUN;
            end
        endcase
    end

    // Register port; a set in the same cycle as a write-one clear wins.
    always_comb
    begin
        evmask_d = evmask_q;
        en_d     = en_q;
        ev_d     = ev_q;
        rdata_d  = 32'h0000_0000;
        if (i_wr && i_addr == REG_STATUS)
        begin
            ev_d = ev_q & ~i_wdata[EV_W-1:0];
        end
        else if (i_wr && i_addr == REG_MASK)
        begin
            evmask_d = i_wdata[EV_W-1:0];
        end
        else if (i_wr && i_addr == REG_ENABLE)
        begin
            en_d = i_wdata[NSRC-1:0];
        end
        ev_d = ev_d | ev_set;
        if (i_rd && i_addr == REG_FLAGS)
        begin
            rdata_d[7:0]  = ccr_byte;
            rdata_d[8]    = brk_act_q;
            rdata_d[11:9] = state_q;
        end
        else if (i_rd && i_addr == REG_STATUS)
        begin
            rdata_d[EV_W-1:0] = ev_q;
        end
        else if (i_rd && i_addr == REG_MASK)
        begin
            rdata_d[EV_W-1:0] = evmask_q;
        end
        else if (i_rd && i_addr == REG_ENABLE)
        begin
            rdata_d[NSRC-1:0] = en_q;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_resetn)
        begin
            state_q   <= ST_RUN;
            cnt_q     <= '0;
            i_flag_q  <= RST_MASK_FLAG;
            n_flag_q  <= 1'b0;
            z_flag_q  <= 1'b0;
            brk_act_q <= 1'b0;
            sdata_q   <= 8'h00;
            vaddr_q   <= 16'h0000;
            ev_q      <= '0;
            evmask_q  <= RST_EVMASK;
            en_q      <= NSRC'(RST_ENABLE);
            rdata_q   <= 32'h0000_0000;
        end
        else if (i_ce)
        begin
            state_q   <= state_d;
            cnt_q     <= cnt_d;
            i_flag_q  <= i_flag_d;
            n_flag_q  <= n_flag_d;
            z_flag_q  <= z_flag_d;
            brk_act_q <= brk_act_d;
            sdata_q   <= sdata_d;
            vaddr_q   <= vaddr_d;
            ev_q      <= ev_d;
            evmask_q  <= evmask_d;
            en_q      <= en_d;
            rdata_q   <= rdata_d;
        end
    end

    assign o_rdata      = rdata_q;
    assign o_irq        = |(ev_q & evmask_q);
    assign o_busy       = (state_q != ST_RUN);
    assign o_cpu_clk_en = (state_q != ST_STOP) && (state_q != ST_STAB);
    assign o_stack_wr   = (state_q == ST_PUSH);
    assign o_stack_rd   = (state_q == ST_PULL);
    assign o_stack_idx  = cnt_q[2:0];
    assign o_stack_data = sdata_q;
    assign o_vec_fetch  = (state_q == ST_VEC);
    assign o_vec_addr   = vaddr_q;
    assign o_mask_flag  = i_flag_q;
    assign o_neg_flag   = n_flag_q;
    assign o_zero_flag  = z_flag_q;

    chk_mask_blocks_irq: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (i_ce && state_q == ST_RUN && i_boundary && i_flag_q && !brk_take
         && !i_rti_exec && !i_stop_exec) |=> state_q != ST_PUSH)
        else $error("Masked request was taken.");
    chk_mask_after_push: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (i_ce && state_q == ST_PUSH && cnt_q[2:0] == STACK_LAST) |=> i_flag_q && o_vec_fetch)
        else $error("Mask not set before vector fetch.");
    chk_push_byte_count: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        o_vec_fetch |-> $past(o_stack_idx) == STACK_LAST && cnt_q[2:0] == STACK_LAST)
        else $error("Wrong number of stacked bytes.");
    chk_pull_restores: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (i_ce && state_q == ST_PULL && cnt_q == '0) |=> i_flag_q == $past(i_stack_rdata[CCR_I]))
        else $error("Mask not restored from stack.");
    chk_reset_sets_mask: assert property (@(posedge i_ref_clk)
        !i_resetn |=> i_flag_q)
        else $error("Reset left mask clear.");
    chk_result_flags: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (i_ce && state_q == ST_RUN && i_alu_valid) |=>
        n_flag_q == $past(i_alu_result[7]) && z_flag_q == ($past(i_alu_result) == 8'h00))
        else $error("Result flags wrong.");
    chk_stop_entry: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (i_ce && state_q == ST_RUN && i_stop_exec && !i_rti_exec) |=>
        !i_flag_q && !o_cpu_clk_en)
        else $error("Stop entry wrong.");
    chk_stab_wait: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        $rose(o_cpu_clk_en) |-> $past(cnt_q) == STAB_LAST && !i_flag_q)
        else $error("Clock restarted early.");
    chk_break_vector: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (i_ce && state_q == ST_RUN && i_boundary && brk_take && !i_rti_exec && !i_stop_exec)
        |=> o_vec_addr == ($past(i_monitor) ? VEC_BRK_MON : VEC_BRK_NORMAL))
        else $error("Break vector wrong.");
    chk_break_release: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (i_ce && state_q == ST_PULL && cnt_q[2:0] == STACK_LAST && i_break_req && brk_act_q)
        |=> brk_act_q)
        else $error("Break ended while still requested.");
endmodule
`default_nettype wire

//--- hw/cimsb_pkg.sv
// Shared constants for the interrupt mask, stop and break control unit.
package cimsb_pkg;

    // Register map, byte addresses on the plain register port.
    localparam logic [3:0] REG_FLAGS   = 4'h0;
    localparam logic [3:0] REG_STATUS  = 4'h4;
    localparam logic [3:0] REG_MASK    = 4'h8;
    localparam logic [3:0] REG_ENABLE  = 4'hc;

    // Status and mask bit positions.
    localparam int EV_INT   = 0;
    localparam int EV_BRK   = 1;
    localparam int EV_WAKE  = 2;
    localparam int EV_W     = 3;

    // Condition code byte layout.
    localparam int CCR_V    = 7;
    localparam int CCR_H    = 4;
    localparam int CCR_I    = 3;
    localparam int CCR_N    = 2;
    localparam int CCR_Z    = 1;
    localparam int CCR_C    = 0;

    // Values after reset.
    localparam logic         RST_MASK_FLAG = 1'b1;
    localparam logic [7:0]   RST_ENABLE    = 8'h00;
    localparam logic [EV_W-1:0] RST_EVMASK = 3'h0;

    // Vector addresses.
    localparam logic [15:0]  VEC_BRK_NORMAL = 16'hfffc;
    localparam logic [15:0]  VEC_BRK_MON    = 16'hfefc;
    localparam logic [15:0]  VEC_IRQ_TOP    = 16'hfffa;

    // Bytes stacked on entry: PC low, PC high, X low, A, CONDITION_CODE_REGISTER.
    localparam logic [2:0]   STACK_BYTES    = 3'h5;
    localparam logic [2:0]   STACK_LAST     = 3'h4;

    // Oscillator stabilisation wait.
    localparam int CLK_PERIOD_NS = 40;
    localparam int OSC_STAB_NS   = 163840;
    localparam int OSC_STAB_CYC  = OSC_STAB_NS / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        ST_RUN  = 3'b000,
        ST_PUSH = 3'b001,
        ST_VEC  = 3'b010,
        ST_PULL = 3'b011,
        ST_STOP = 3'b100,
        ST_STAB = 3'b101
    } cimsb_state_type;

endpackage

//--- hw/cimsb_sync.sv
// Two flip-flop synchroniser for pin-level inputs.
`timescale 1ns/100ps
`default_nettype none
module cimsb_sync #(
    parameter int W = 1
) (
    input  wire logic         i_ref_clk, // Bus clock.
    input  wire logic         i_resetn,  // Synchronous reset, active low.
    input  wire logic         i_ce,      // Clock enable.
    input  wire logic [W-1:0] i_async,   // Raw pin levels.
    output logic      [W-1:0] o_sync     // Synchronised levels.
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_resetn)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else if (i_ce)
        begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;
endmodule
`default_nettype wire

//--- hw/cimsb_prio.sv
// Fixed priority picker: the lowest numbered request wins.
`timescale 1ns/100ps
`default_nettype none
module cimsb_prio #(
    parameter int N  = 8,
    parameter int IW = 3
) (
    input  wire logic [N-1:0]  i_req,   // Enabled pending requests.
    output logic               o_valid, // Any request present.
    output logic [IW-1:0]      o_index  // Winning request number.
);
    always_comb
    begin
        o_valid = 1'b0;
        o_index = '0;
        for (int k = N - 1; k >= 0; k--)
        begin
            if (i_req[k])
            begin
                o_valid = 1'b1;
                o_index = IW'(k);
            end
        end
    end
endmodule
`default_nettype wire

//--- testbench/cimsb_src_model.sv
// Behavioural peripheral request sources and break module.
`timescale 1ns/100ps
`default_nettype none
module cimsb_src_model
    import cimsb_pkg::*;
(
    input  wire logic        i_ref_clk,     // Bus clock.
    input  wire logic        i_vec_fetch,   // Vector fetch pulse.
    input  wire logic [15:0] i_vec_addr,    // Vector being fetched.
    output logic             o_ext_irq_pin, // External pin level.
    output logic      [7:1]  o_irq_req,     // Peripheral request levels.
    output logic             o_break_req    // Break request level.
);
    logic [7:0] pend  = 8'h00;
    logic       brk_q = 1'b0;
    assign o_ext_irq_pin = pend[0];
    assign o_irq_req     = pend[7:1];
    assign o_break_req   = brk_q;
    task raise(input int k);
        @(posedge i_ref_clk) pend[k] <= 1'b1;
    endtask
    task brk(input logic v);
        @(posedge i_ref_clk) brk_q <= v;
    endtask
    // Sources acknowledge on their own vector, as a peripheral flag clear would.
    always @(posedge i_ref_clk)
    begin
        if (i_vec_fetch)
        begin
            // Break request drops before the return.
            if (i_vec_addr == VEC_BRK_NORMAL || i_vec_addr == VEC_BRK_MON) brk_q <= 1'b0;
            for (int k = 0; k < 8; k++)
                if (i_vec_addr == VEC_IRQ_TOP - 16'(2 * k)) pend[k] <= 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- testbench/cimsb_core_tb_top.sv
// Self-checking bench for the interrupt mask, stop and break core.
`timescale 1ns/100ps
`default_nettype none
module cimsb_core_tb_top
    import cimsb_pkg::*;
;
    logic        clk = 0, rstn = 0, av = 0, wr = 0, rd = 0, rd_d = 0, av_d = 0;
    logic        ben = 0, mon = 0, mold = 0, ce = 1;
    logic [4:0]  ex = 0;
    logic [7:0]  res = 0, srd = 0, acc = 0, xl = 0, sdata;
    logic [15:0] pc = 0, vaddr;
    logic [2:0]  vhc = 0, sidx;
    logic [3:0]  addr = 0;
    logic [31:0] wd = 0, rdata, seed = 32'h3ab987f8;
    logic        irq, busy, clk_en, swr, srdq, vf, mask, neg, zero, ext, breq;
    logic [7:1]  req;
    int          fail_count = 0, total_checks = 0, n;
    logic [31:0] rq[$], vq[$], fq[$];
    wire  [31:0] sb = {acc, xl, pc};

    cimsb_core #(.NSRC(8), .STAB_CYCLES(8)) i_dut (.i_ref_clk(clk), .i_resetn(rstn),
        .i_ce(ce), .i_boundary(ex[0]), .i_cli_exec(ex[1]), .i_sei_exec(ex[2]),
        .i_stop_exec(ex[3]), .i_rti_exec(ex[4]), .i_alu_valid(av), .i_alu_result(res),
        .i_ccr_vhc(vhc), .i_pc(pc), .i_acc(acc), .i_idx_lo(xl), .i_stack_rdata(srd),
        .i_ext_irq_pin(ext), .i_irq_req(req), .i_break_en(ben), .i_break_req(breq),
        .i_monitor(mon), .i_addr(addr), .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .o_irq(irq), .o_busy(busy), .o_cpu_clk_en(clk_en), .o_stack_wr(swr),
        .o_stack_rd(srdq), .o_stack_idx(sidx), .o_stack_data(sdata), .o_vec_fetch(vf),
        .o_vec_addr(vaddr), .o_mask_flag(mask), .o_neg_flag(neg), .o_zero_flag(zero));
    cimsb_src_model i_model (.i_ref_clk(clk), .i_vec_fetch(vf), .i_vec_addr(vaddr),
        .o_ext_irq_pin(ext), .o_irq_req(req), .o_break_req(breq));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp)
        begin
            fail_count = fail_count + 1;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task close_out;
        check(vq.size() + rq.size() + fq.size(), 0);
        $display("checks=%0d mismatches=%0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task do_reset;
        @(posedge clk) rstn <= 1'b0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
    endtask
    // A read notes the expected word; the monitor compares it a cycle later.
    task reg_op(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= w;
        rd <= !w;
        addr <= a;
        wd <= d;
        if (!w) rq.push_back(d);
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task alu(input logic [7:0] r);
        @(posedge clk);
        av <= 1'b1;
        res <= r;
        fq.push_back({r[7], r == 8'h00});
        @(posedge clk) av <= 1'b0;
    endtask
    // Strobe one instruction pulse; a nonzero vector is noted as expected.
    task fire(input int k, input logic [15:0] v);
        @(posedge clk);
        if (v != 0) vq.push_back(v);
        seed = lfsr(seed);
        pc <= seed[15:0];
        acc <= seed[23:16];
        xl <= seed[31:24];
        vhc <= seed[2:0];
        ex[k] <= 1'b1;
        @(posedge clk) ex[k] <= 1'b0;
        repeat (30)
        begin
            @(negedge clk);
            if (!busy) break;
        end
    endtask

    initial forever #20 clk = ~clk;
    initial
    begin
        repeat (20000) @(posedge clk);
        fail_count = fail_count + 1;
        close_out;
    end
    always @(posedge clk)
    begin
        rd_d <= rd;
        av_d <= av;
        if (rd_d) check(rdata, rq.pop_front());
        if (av_d) check({neg, zero}, fq.pop_front());
        if (vf)
        begin
            check(mask, 1'b1);
            check(vaddr, vq.size() != 0 ? vq.pop_front() : 32'hdead);
        end
        if (swr && sidx == 3'h4) check(sdata[CCR_I], mold);
        else if (swr) check(sdata, sb[8*sidx +: 8]);
    end

    initial
    begin
        do_reset;
        @(negedge clk);
        check({mask, clk_en, neg, zero}, 4'hc);
        reg_op(1'b0, REG_FLAGS, 32'h68);
        reg_op(1'b1, REG_ENABLE, 32'hff);
        reg_op(1'b1, REG_MASK, 32'h1);
        reg_op(1'b0, REG_ENABLE, 32'hff);
        reg_op(1'b0, 4'h2, 32'h0);
        for (int i = 0; i < 6; i++)
        begin
            seed = lfsr(seed);
            alu(i == 0 ? 8'h00 : i == 1 ? 8'h80 : seed[7:0]);
        end
        i_model.raise(3);
        i_model.raise(5);
        fire(0, 16'h0);
        fire(1, 16'h0);
        fire(0, 16'hfff4);
        check(irq, 1'b1);
        reg_op(1'b0, REG_STATUS, 32'h1);
        reg_op(1'b1, REG_STATUS, 32'h1);
        @(negedge clk) check(irq, 1'b0);
        // Pulled flags byte: mask clear, negative set.
        @(posedge clk) srd <= 8'h64;
        fire(4, 16'h0);
        check({mask, neg}, 2'b01);
        fire(0, 16'hfff0);
        fire(4, 16'h0);
        fire(2, 16'h0);
        check(mask, 1'b1);
        // A frozen core must ignore the clear-mask pulse.
        @(posedge clk) ce <= 1'b0;
        fire(1, 16'h0);
        check(mask, 1'b1);
        @(posedge clk) ce <= 1'b1;
        fire(1, 16'h0);
        fire(3, 16'h0);
        check({mask, clk_en}, 2'b00);
        i_model.raise(0);
        n = 0;
        repeat (40)
        begin
            @(negedge clk);
            if (clk_en) break;
            n = n + 1;
        end
        check(n >= 8 && n <= 16, 1'b1);
        check(mask, 1'b0);
        fire(0, VEC_IRQ_TOP);
        fire(4, 16'h0);
        fire(3, 16'h0);
        do_reset;
        @(negedge clk) check({mask, clk_en}, 2'b11);
        mold = 1'b1;
        i_model.brk(1'b1);
        fire(0, 16'h0);
        @(posedge clk) ben <= 1'b1;
        fire(0, VEC_BRK_NORMAL);
        // Request still held at the return: the break must stay active.
        i_model.brk(1'b1);
        i_model.raise(6);
        fire(4, 16'h0);
        fire(0, 16'h0);
        reg_op(1'b0, REG_FLAGS, {23'h0, 1'b1, vhc[2], 2'b11, vhc[1], 3'b010, vhc[0]});
        i_model.brk(1'b0);
        fire(4, 16'h0);
        @(posedge clk) mon <= 1'b1;
        mold = 1'b0;
        i_model.brk(1'b1);
        fire(0, VEC_BRK_MON);
        fire(4, 16'h0);
        close_out;
    end
endmodule
`default_nettype wire
